// file: logic/iopsc_pkg.sv
package iopsc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Data memory geometry
   localparam int         DM_ADDR_W = 7;
   localparam int         NIB_W     = 4;

   // Port register addresses in data memory
   localparam logic [6:0] OPEN_DRAIN_PORT_DATA_ADDR  = 7'h71;
   localparam logic [6:0] PUSH_PULL_PORT_A_DATA_ADDR = 7'h72;
   localparam logic [6:0] PUSH_PULL_PORT_B_DATA_ADDR = 7'h73;

   // Port widths and the open-drain port's usable bits
   localparam int         OPEN_DRAIN_USED = 3;
   localparam int         PUSH_PULL_USED  = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int         OPND_WAKE_BIT   = 0;   // Release select in the operand
   localparam int         HALT_PIN_BIT    = 0;   // Open-drain bit used as halt release
   localparam int         STOP_PIN_BIT    = 1;   // Open-drain bit used as stop release

   // Values after reset
   localparam logic       DIR_RESET       = 1'b0;          // Input mode
   localparam logic [3:0] RDATA_RESET     = 4'h0;
   localparam logic       SYNC_RESET      = 1'b1;          // Pins idle high: no false wake edge

   // Oscillator stabilisation wait, counted in oscillator input pulses
   localparam int         OSC_WAIT_PULSES = 8;
   localparam int         WAIT_CNT_W      = 3;
   localparam logic [2:0] WAIT_CNT_RESET  = 3'h0;
   localparam logic [2:0] WAIT_CNT_LAST   = 3'(OSC_WAIT_PULSES - 1);

   // Standby sequencer states
   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_HALT = 2'b01,
      ST_STOP = 2'b10,
      ST_WAIT = 2'b11
   } iopsc_state_t;

endpackage

// file: logic/iopsc_sync.sv
module iopsc_sync
   import iopsc_pkg::*;
#(
   parameter int WIDTH = 11
)
(
   // Clock and reset
   input  wire  logic             clk,
   input  wire  logic             rst_b,
   // Asynchronous levels in, synchronised levels out
   input  wire  logic [WIDTH-1:0] async_in,
   output logic       [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;
   logic [WIDTH-1:0] next_stage_one;
   logic [WIDTH-1:0] next_sync_out;

   if (WIDTH < 1)
   begin : g_chk
      $error("iopsc_sync needs at least one bit");
   end

   ////////////////////////////////////////////////////////////////////////////
   // First stage feeds only the second; nothing else may look at it
   always_comb
   begin
      next_stage_one = async_in;
      next_sync_out  = stage_one;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stage_one <= {WIDTH{SYNC_RESET}};
         sync_out  <= {WIDTH{SYNC_RESET}};
      end
      else
      begin
         stage_one <= next_stage_one;
         sync_out  <= next_sync_out;
      end
   end

endmodule

// file: logic/iopsc_port.sv
module iopsc_port
   import iopsc_pkg::*;
#(
   parameter int USED       = 4,
   parameter bit OPEN_DRAIN = 1'b0
)
(
   // Clock and reset
   input  wire  logic            clk,
   input  wire  logic            rst_b,
   // Register access
   input  wire  logic            wr_en,
   input  wire  logic [3:0]      wr_data,
   input  wire  logic            soft_clr,
   output logic       [3:0]      rd_data,
   // Pins, input already synchronised
   input  wire  logic [USED-1:0] pin_sync,
   output logic       [USED-1:0] pin_out,
   output logic       [USED-1:0] pin_oe
);

   logic            dir;
   logic            next_dir;
   logic [USED-1:0] data;
   logic [USED-1:0] next_data;

   if (USED < 1 || USED > 4)
   begin : g_chk
      $error("iopsc_port serves one to four bits");
   end

   ////////////////////////////////////////////////////////////////////////////
   // One direction flag per port; write sets, reset or standby clear drops
   always_comb
   begin
      next_dir  = dir;
      next_data = data;
      if (soft_clr)
      begin
         next_dir = DIR_RESET;
      end
      else if (wr_en)
      begin
         next_dir  = 1'b1;
         next_data = wr_data[USED-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dir <= DIR_RESET;
      end
      else
      begin
         dir <= next_dir;
      end
   end

   // Latch is kept across reset on purpose: only direction is initialised
   always_ff @(posedge clk)
   begin
      data <= next_data;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers; open-drain only ever pulls low
   always_comb
   begin
      if (OPEN_DRAIN)
      begin
         pin_out = '0;
         pin_oe  = {USED{dir}} & ~data;
      end
      else
      begin
         pin_out = {USED{dir}} & data;
         pin_oe  = {USED{dir}};
      end
      rd_data = 4'h0;
      rd_data[USED-1:0] = pin_sync;
   end

endmodule

// file: logic/iopsc_top.sv
// Overview of operation
// - Open-drain port: three bits, input after reset
// - Writing 71h drives open-drain pins with data
// - Port reads return pin levels, not latch
// - Open-drain top bit ignores writes, reads zero
// - Port A input at reset, write 72h outputs
// - Port B input at reset, write 73h outputs
// - Two low open-drain pins wake standby modes
// - HALT freezes program counter, clock keeps running
// - Pin release of HALT resumes without wait
// - Reset releases standby as ordinary system reset
// - STOP halts the oscillator
// - Pin release of STOP resumes after instruction
// - Operand bit zero selects the release condition
// - HALT operand zero: only reset ends it
// - HALT operand one: enter if pin low, edge releases
// - STOP operand zero: clear peripherals, reset only
// - STOP operand one: enter if pin low, edge releases
// - After reset, hold eight oscillator pulses
// - Reset restarts oscillator, then stabilisation hold
// - Pin release of STOP waits eight pulses
module iopsc_top
   import iopsc_pkg::*;
(
   // Clock and reset
   input  wire  logic       clk,
   input  wire  logic       rst_b,
   // Data memory access from the core
   input  wire  logic [6:0] dm_addr,
   input  wire  logic       dm_wr,
   input  wire  logic       dm_rd,
   input  wire  logic [3:0] dm_wdata,
   output logic       [3:0] dm_rdata,
   // Standby instructions from the core
   input  wire  logic       halt_cmd,
   input  wire  logic       stop_cmd,
   input  wire  logic [3:0] cmd_operand,
   // Standby control to the core and oscillator
   output logic             cpu_hold,
   output logic             osc_run,
   output logic             periph_clr,
   output logic       [1:0] standby_state,
   // Open-drain port pins
   input  wire  logic [2:0] open_drain_pin_in,
   output logic       [2:0] open_drain_pin_out,
   output logic       [2:0] open_drain_pin_oe,
   // Push-pull port A pins
   input  wire  logic [3:0] push_pull_a_pin_in,
   output logic       [3:0] push_pull_a_pin_out,
   output logic       [3:0] push_pull_a_pin_oe,
   // Push-pull port B pins
   input  wire  logic [3:0] push_pull_b_pin_in,
   output logic       [3:0] push_pull_b_pin_out,
   output logic       [3:0] push_pull_b_pin_oe
);

   // Synchronised pins
   logic [10:0]  pins_sync;
   logic [2:0]   od_sync;
   logic [3:0]   ppa_sync;
   logic [3:0]   ppb_sync;

   // Register access
   logic         wr_od;
   logic         wr_ppa;
   logic         wr_ppb;
   logic [3:0]   rd_od;
   logic [3:0]   rd_ppa;
   logic [3:0]   rd_ppb;
   logic [3:0]   next_dm_rdata;

   // Standby sequencer
   iopsc_state_t state;
   iopsc_state_t next_state;
   logic [2:0]   wait_cnt;
   logic [2:0]   next_wait_cnt;
   logic         halt_wake_en;
   logic         next_halt_wake_en;
   logic         stop_wake_en;
   logic         next_stop_wake_en;
   logic         next_periph_clr;

   // Wake edge detection
   logic         halt_release_pin;
   logic         stop_release_pin;
   logic         halt_pin_prev;
   logic         stop_pin_prev;
   logic         next_halt_pin_prev;
   logic         next_stop_pin_prev;
   logic         halt_rise;
   logic         stop_rise;

   // Address match against one port register
   function automatic logic addr_is(input logic [6:0] addr, input logic [6:0] offset);
      addr_is = (addr == offset);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Every pin is external, so all pass the two-stage synchroniser
   iopsc_sync #(
      .WIDTH (11)
   ) u_sync (
      .clk      (clk),
      .rst_b    (rst_b),
      .async_in ({push_pull_b_pin_in, push_pull_a_pin_in, open_drain_pin_in}),
      .sync_out (pins_sync)
   );

   assign od_sync  = pins_sync[2:0];
   assign ppa_sync = pins_sync[6:3];
   assign ppb_sync = pins_sync[10:7];

   ////////////////////////////////////////////////////////////////////////////
   // Write strobes per port register
   assign wr_od  = dm_wr && addr_is(dm_addr, OPEN_DRAIN_PORT_DATA_ADDR);
   assign wr_ppa = dm_wr && addr_is(dm_addr, PUSH_PULL_PORT_A_DATA_ADDR);
   assign wr_ppb = dm_wr && addr_is(dm_addr, PUSH_PULL_PORT_B_DATA_ADDR);

   iopsc_port #(
      .USED       (OPEN_DRAIN_USED),
      .OPEN_DRAIN (1'b1)
   ) u_open_drain_port (
      .clk      (clk),
      .rst_b    (rst_b),
      .wr_en    (wr_od),
      .wr_data  (dm_wdata),
      .soft_clr (periph_clr),
      .rd_data  (rd_od),
      .pin_sync (od_sync),
      .pin_out  (open_drain_pin_out),
      .pin_oe   (open_drain_pin_oe)
   );

   iopsc_port #(
      .USED       (PUSH_PULL_USED),
      .OPEN_DRAIN (1'b0)
   ) u_push_pull_port_a (
      .clk      (clk),
      .rst_b    (rst_b),
      .wr_en    (wr_ppa),
      .wr_data  (dm_wdata),
      .soft_clr (periph_clr),
      .rd_data  (rd_ppa),
      .pin_sync (ppa_sync),
      .pin_out  (push_pull_a_pin_out),
      .pin_oe   (push_pull_a_pin_oe)
   );

   iopsc_port #(
      .USED       (PUSH_PULL_USED),
      .OPEN_DRAIN (1'b0)
   ) u_push_pull_port_b (
      .clk      (clk),
      .rst_b    (rst_b),
      .wr_en    (wr_ppb),
      .wr_data  (dm_wdata),
      .soft_clr (periph_clr),
      .rd_data  (rd_ppb),
      .pin_sync (ppb_sync),
      .pin_out  (push_pull_b_pin_out),
      .pin_oe   (push_pull_b_pin_oe)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read data; other addresses return zero, latch stays untouched
   always_comb
   begin
      next_dm_rdata = dm_rdata;
      if (dm_rd)
      begin
         if (addr_is(dm_addr, OPEN_DRAIN_PORT_DATA_ADDR))
         begin
            next_dm_rdata = rd_od;
         end
         else if (addr_is(dm_addr, PUSH_PULL_PORT_A_DATA_ADDR))
         begin
            next_dm_rdata = rd_ppa;
         end
         else if (addr_is(dm_addr, PUSH_PULL_PORT_B_DATA_ADDR))
         begin
            next_dm_rdata = rd_ppb;
         end
         else
         begin
            next_dm_rdata = RDATA_RESET;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dm_rdata <= RDATA_RESET;
      end
      else
      begin
         dm_rdata <= next_dm_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wake pins share the open-drain port; edges seen on synchronised levels
   assign halt_release_pin = od_sync[HALT_PIN_BIT];
   assign stop_release_pin = od_sync[STOP_PIN_BIT];
   assign halt_rise = halt_release_pin && !halt_pin_prev;
   assign stop_rise = stop_release_pin && !stop_pin_prev;

   always_comb
   begin
      next_halt_pin_prev = halt_release_pin;
      next_stop_pin_prev = stop_release_pin;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         halt_pin_prev <= SYNC_RESET;
         stop_pin_prev <= SYNC_RESET;
      end
      else
      begin
         halt_pin_prev <= next_halt_pin_prev;
         stop_pin_prev <= next_stop_pin_prev;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Standby sequencer; reset lands in the wait state so the core
   // only starts after the oscillator has had its pulses
   always_comb
   begin
      next_state        = state;
      next_wait_cnt     = wait_cnt;
      next_halt_wake_en = halt_wake_en;
      next_stop_wake_en = stop_wake_en;
      next_periph_clr   = 1'b0;
      unique case (state)
         ST_RUN:
         begin
            if (halt_cmd)
            begin
               if (!cmd_operand[OPND_WAKE_BIT])
               begin
                  next_state        = ST_HALT;
                  next_halt_wake_en = 1'b0;
               end
               else if (!halt_release_pin)
               begin
                  next_state        = ST_HALT;
                  next_halt_wake_en = 1'b1;
               end
            end
            else if (stop_cmd)
            begin
               if (!cmd_operand[OPND_WAKE_BIT])
               begin
                  next_state        = ST_STOP;
                  next_stop_wake_en = 1'b0;
                  next_periph_clr   = 1'b1;
               end
               else if (!stop_release_pin)
               begin
                  next_state        = ST_STOP;
                  next_stop_wake_en = 1'b1;
               end
            end
         end
         ST_HALT:
         begin
            // No oscillator wait: the clock never stopped
            if (halt_wake_en && halt_rise)
            begin
               next_state = ST_RUN;
            end
         end
         ST_STOP:
         begin
            if (stop_wake_en && stop_rise)
            begin
               next_state    = ST_WAIT;
               next_wait_cnt = WAIT_CNT_RESET;
            end
         end
         ST_WAIT:
         begin
            if (wait_cnt == WAIT_CNT_LAST)
            begin
               next_state    = ST_RUN;
               next_wait_cnt = WAIT_CNT_RESET;
            end
            else
            begin
               next_wait_cnt = wait_cnt + 3'h1;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state        <= ST_WAIT;
         wait_cnt     <= WAIT_CNT_RESET;
         halt_wake_en <= 1'b0;
         stop_wake_en <= 1'b0;
         periph_clr   <= 1'b0;
      end
      else
      begin
         state        <= next_state;
         wait_cnt     <= next_wait_cnt;
         halt_wake_en <= next_halt_wake_en;
         stop_wake_en <= next_stop_wake_en;
         periph_clr   <= next_periph_clr;
      end
   end

   // Core sees a frozen PC in any non-run state; oscillator off only in STOP
   assign cpu_hold      = (state != ST_RUN);
   assign osc_run       = (state != ST_STOP);
   assign standby_state = state;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_osc_wait;
      (state == ST_WAIT && cpu_hold)[*8] ##1 (state == ST_RUN);
   endsequence

   sequence s_halt_pin_enter;
      (state == ST_RUN) && halt_cmd && cmd_operand[OPND_WAKE_BIT] && !halt_release_pin;
   endsequence

   a_halt_freezes_pc: assert property (@(posedge clk) disable iff (!rst_b)
      (state == ST_HALT) |-> (cpu_hold && osc_run))
      else $error("HALT must hold the core with the clock running");

   a_halt_zero_stays: assert property (@(posedge clk) disable iff (!rst_b)
      ((state == ST_RUN) && halt_cmd && !cmd_operand[0]) |=>
         (state == ST_HALT) [*2])
      else $error("HALT with operand zero left without reset");

   a_halt_pin_enter: assert property (@(posedge clk) disable iff (!rst_b)
      s_halt_pin_enter |=> (state == ST_HALT && halt_wake_en))
      else $error("HALT with a low release pin was not entered");

   a_halt_pin_wake: assert property (@(posedge clk) disable iff (!rst_b)
      ((state == ST_HALT) && halt_wake_en && halt_rise) |=> (state == ST_RUN))
      else $error("Rising halt release pin did not resume the core");

   // Leaving HALT must go straight to run, never through the wait
   a_halt_no_wait: assert property (@(posedge clk) disable iff (!rst_b)
      (state == ST_HALT) |=> (state == ST_HALT || state == ST_RUN))
      else $error("HALT left through the oscillator wait");

   a_halt_pin_high: assert property (@(posedge clk) disable iff (!rst_b)
      ((state == ST_RUN) && halt_cmd && cmd_operand[0] && halt_release_pin) |=>
         (state == ST_RUN))
      else $error("HALT entered while the release pin was high");

   a_stop_clears: assert property (@(posedge clk) disable iff (!rst_b)
      ((state == ST_RUN) && stop_cmd && !halt_cmd && !cmd_operand[0]) |=>
         (state == ST_STOP && periph_clr && !osc_run) ##1
         (push_pull_a_pin_oe == 4'h0 && open_drain_pin_oe == 3'h0))
      else $error("STOP with operand zero did not clear the ports");

   a_stop_pin_wait: assert property (@(posedge clk) disable iff (!rst_b)
      ((state == ST_STOP) && stop_wake_en && stop_rise) |=> s_osc_wait)
      else $error("STOP release did not wait eight pulses");

   a_wait_eight: assert property (@(posedge clk) disable iff (!rst_b)
      ((state == ST_WAIT) && wait_cnt == 3'h0) |-> s_osc_wait)
      else $error("Oscillator wait is not eight pulses long");

   a_od_drive: assert property (@(posedge clk) disable iff (!rst_b)
      (wr_od && !periph_clr) |=>
         (open_drain_pin_oe == ~$past(dm_wdata[2:0]) && open_drain_pin_out == 3'h0))
      else $error("Open-drain port does not drive the written value");

   a_ppa_output: assert property (@(posedge clk) disable iff (!rst_b)
      (wr_ppa && !periph_clr) |=> (push_pull_a_pin_oe == 4'hf &&
         push_pull_a_pin_out == $past(dm_wdata)))
      else $error("Port A not switched to output by a write");

   a_read_pins: assert property (@(posedge clk) disable iff (!rst_b)
      (dm_rd && dm_addr == PUSH_PULL_PORT_B_DATA_ADDR) |=> (dm_rdata == $past(ppb_sync)))
      else $error("Port read did not return pin levels");

   a_od_top_zero: assert property (@(posedge clk) disable iff (!rst_b)
      (dm_rd && dm_addr == OPEN_DRAIN_PORT_DATA_ADDR) |=>
         (dm_rdata == {1'b0, $past(od_sync)}))
      else $error("Open-drain top bit did not read zero");

endmodule

// file: test/iopsc_ext_model.sv
module iopsc_ext_model
   import iopsc_pkg::*;
(
   // Block side of the pins
   input  wire  logic [2:0] od_oe,
   input  wire  logic [3:0] a_out,
   input  wire  logic [3:0] a_oe,
   input  wire  logic [3:0] b_out,
   input  wire  logic [3:0] b_oe,
   // Far-side drivers
   input  wire  logic [2:0] od_low,
   input  wire  logic [3:0] a_val,
   input  wire  logic [3:0] b_val,
   // Resolved pin levels
   output logic       [2:0] od_pin,
   output logic       [3:0] a_pin,
   output logic       [3:0] b_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////
   // Pull-up wins unless either side sinks the line
   assign od_pin = ~(od_oe | od_low);
   // Far side yields wherever the block drives, so no contention
   assign a_pin = (a_oe & a_out) | (~a_oe & a_val);
   assign b_pin = (b_oe & b_out) | (~b_oe & b_val);
endmodule

// file: test/iopsc_top_tb.sv
module iopsc_top_tb
   import iopsc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   // Design signals
   logic       clk, rst_b, dm_wr, dm_rd, halt_cmd, stop_cmd;
   logic       cpu_hold, osc_run, periph_clr;
   logic [6:0] dm_addr;
   logic [3:0] dm_wdata, dm_rdata, cmd_operand;
   logic [1:0] standby_state;
   logic [2:0] od_in, od_out, od_oe, od_low;
   logic [3:0] a_in, a_out, a_oe, b_in, b_out, b_oe, a_val, b_val;
   // Reference model state
   logic [3:0] exp_dat [3];
   logic       exp_dir [3];
   logic       saw;
   int         n_mismatch, compares, seed, n;

   iopsc_top u_iopsc_top (.clk(clk), .rst_b(rst_b), .dm_addr(dm_addr), .dm_wr(dm_wr),
      .dm_rd(dm_rd), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .halt_cmd(halt_cmd),
      .stop_cmd(stop_cmd), .cmd_operand(cmd_operand), .cpu_hold(cpu_hold),
      .osc_run(osc_run), .periph_clr(periph_clr), .standby_state(standby_state),
      .open_drain_pin_in(od_in), .open_drain_pin_out(od_out), .open_drain_pin_oe(od_oe),
      .push_pull_a_pin_in(a_in), .push_pull_a_pin_out(a_out), .push_pull_a_pin_oe(a_oe),
      .push_pull_b_pin_in(b_in), .push_pull_b_pin_out(b_out), .push_pull_b_pin_oe(b_oe));

   iopsc_ext_model u_iopsc_ext_model (.od_oe(od_oe), .a_out(a_out), .a_oe(a_oe),
      .b_out(b_out), .b_oe(b_oe), .od_low(od_low), .a_val(a_val), .b_val(b_val),
      .od_pin(od_in), .a_pin(a_in), .b_pin(b_in));

   ////////////////////////////////////////////////////////////////////////////
   // Clock
   initial
   begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end

   // Hang guard, far beyond the few hundred cycles needed
   initial
   begin
      #(25 * 20000);
      n_mismatch++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Settle one step after the edge so its updates have landed
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [6:0] a, input logic [3:0] d);
      @(posedge clk);
      dm_addr  <= a;
      dm_wdata <= d;
      dm_wr    <= 1'h1;
      @(posedge clk);
      dm_wr <= 1'h0;
      #1;
   endtask

   task automatic rd(input logic [6:0] a, output logic [3:0] d);
      @(posedge clk);
      dm_addr <= a;
      dm_rd   <= 1'h1;
      @(posedge clk);
      dm_rd <= 1'h0;
      #1;
      d = dm_rdata;
   endtask

   task automatic cmd(input logic h, input logic [3:0] op);
      @(posedge clk);
      halt_cmd    <= h;
      stop_cmd    <= ~h;
      cmd_operand <= op;
      @(posedge clk);
      halt_cmd <= 1'h0;
      stop_cmd <= 1'h0;
      #1;
   endtask

   // Counts edges until state s is reached; flags any pass through the wait state
   task automatic poll(input logic [1:0] s);
      n   = 0;
      saw = 1'h0;
      while (standby_state !== s && n < 40)
      begin
         tick(1);
         n++;
         if (standby_state === ST_WAIT)
            saw = 1'h1;
      end
   endtask

   task automatic check_pins();
      logic [2:0] e;
      e = exp_dir[0] ? ~exp_dat[0][2:0] : 3'h0;
      check("od_oe", od_oe, e);
      check("od_out", od_out, 8'h00);
      check("a_oe", a_oe, {4{exp_dir[1]}});
      check("b_oe", b_oe, {4{exp_dir[2]}});
      if (exp_dir[1])
         check("a_out", a_out, exp_dat[1]);
      if (exp_dir[2])
         check("b_out", b_out, exp_dat[2]);
   endtask

   // Reads see pin levels; the unmapped slot after the ports reads zero
   task automatic check_reads();
      logic [3:0] d;
      logic [3:0] ex [4];
      ex[0] = {1'h0, ~(od_low | (exp_dir[0] ? ~exp_dat[0][2:0] : 3'h0))};
      ex[1] = exp_dir[1] ? exp_dat[1] : a_val;
      ex[2] = exp_dir[2] ? exp_dat[2] : b_val;
      ex[3] = 4'h0;
      for (int i = 0; i < 4; i++)
      begin
         rd(7'h71 + 7'(i), d);
         check("read", d, ex[i]);
      end
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst_b <= 1'h0;
      for (int i = 0; i < 3; i++)
         exp_dir[i] = 1'h0;
      tick(2);
      check("osc_run in reset", osc_run, 8'h01);
      check("state in reset", standby_state, ST_WAIT);
      check_pins();
      repeat (18) @(posedge clk);
      rst_b <= 1'h1;
      poll(ST_RUN);
      check("reset wait", 8'(n), 8'h08);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      rst_b       = 1'h0;
      dm_addr     = 7'h00;
      dm_wr       = 1'h0;
      dm_rd       = 1'h0;
      dm_wdata    = 4'h0;
      halt_cmd    = 1'h0;
      stop_cmd    = 1'h0;
      cmd_operand = 4'h0;
      od_low      = 3'h0;
      a_val       = 4'h9;
      b_val       = 4'h6;
      n_mismatch  = 0;
      compares    = 0;
      seed        = 32'h0855;
      do_reset();
      tick(3);
      check_reads();
      // HALT with operand zero ignores the wake pin
      cmd(1'h1, 4'h0);
      check("halt0 state", standby_state, ST_HALT);
      check("halt0 hold", {cpu_hold, osc_run}, 8'h03);
      cmd(1'h0, 4'h1);
      check("halt0 ignores stop", standby_state, ST_HALT);
      @(posedge clk);
      od_low <= 3'h3;
      tick(3);
      @(posedge clk);
      od_low <= 3'h0;
      tick(6);
      check("halt0 kept", standby_state, ST_HALT);
      do_reset();
      // Operand one with the pin high must not enter standby
      cmd(1'h1, 4'h1);
      tick(1);
      check("halt1 pin high", standby_state, ST_RUN);
      cmd(1'h0, 4'h1);
      tick(1);
      check("stop1 pin high", standby_state, ST_RUN);
      // HALT released by a pin edge, with no oscillator wait
      @(posedge clk);
      od_low <= 3'h1;
      tick(3);
      cmd(1'h1, 4'h1);
      check("halt1 state", standby_state, ST_HALT);
      @(posedge clk);
      od_low <= 3'h0;
      poll(ST_RUN);
      check("halt1 released", {saw, cpu_hold, standby_state}, 8'h00);
      // STOP released by a pin edge, then eight-pulse wait
      @(posedge clk);
      od_low <= 3'h2;
      tick(3);
      cmd(1'h0, 4'h1);
      check("stop1 state", {osc_run, standby_state}, 8'h02);
      @(posedge clk);
      od_low <= 3'h0;
      poll(ST_WAIT);
      check("stop1 osc", {osc_run, cpu_hold}, 8'h03);
      poll(ST_RUN);
      check("stop1 wait", 8'(n), 8'h08);
      // Random writes, one port at a time in turn, each followed by pin-level reads
      for (int k = 0; k < 12; k++)
      begin
         exp_dat[k % 3] = 4'($random(seed));
         exp_dir[k % 3] = 1'h1;
         wr(7'h71 + 7'(k % 3), exp_dat[k % 3]);
         check_pins();
         @(posedge clk);
         od_low <= 3'($random(seed));
         a_val  <= 4'($random(seed));
         b_val  <= 4'($random(seed));
         tick(3);
         check_reads();
      end
      wr(7'h70, 4'hf);
      check_pins();
      // STOP with operand zero clears directions and ignores the pin
      cmd(1'h0, 4'h0);
      check("stop0 clr", {periph_clr, standby_state}, 8'h06);
      tick(1);
      for (int i = 0; i < 3; i++)
         exp_dir[i] = 1'h0;
      check("stop0 pulse", periph_clr, 8'h00);
      check_pins();
      @(posedge clk);
      od_low <= 3'h2;
      tick(3);
      @(posedge clk);
      od_low <= 3'h0;
      tick(6);
      check("stop0 kept", standby_state, ST_STOP);
      do_reset();
      summarize();
   end
endmodule
